// ---- include/peak_hold_defs.svh ----
// Constants for the peak-hold register bank: offsets, widths, reset values.
// Assumes inclusion by bare name from the design files that need them.
`ifndef PEAK_HOLD_DEFS_SVH
`define PEAK_HOLD_DEFS_SVH

// Register offsets on the device register map
`define PEAK_CH3_HIGH_BYTE_ADDR 8'h67
`define PEAK_CH4_LOW_BYTE_ADDR 8'h68
`define PEAK_CH4_HIGH_BYTE_ADDR 8'h69
`define PEAK_CH5_LOW_BYTE_ADDR 8'h6a
`define PEAK_CH5_HIGH_BYTE_ADDR 8'h6b
`define PEAK_CH6_LOW_BYTE_ADDR 8'h6c
`define PEAK_CH6_HIGH_BYTE_ADDR 8'h6d
`define PEAK_CH7_LOW_BYTE_ADDR 8'h6e

// First and last byte covered by this bank
`define PEAK_FIRST_ADDR 8'h67
`define PEAK_LAST_ADDR 8'h6e

// Field layout: channel sits in address bits 3..1, byte select in bit 0
`define PEAK_CHAN_MSB 3
`define PEAK_CHAN_LSB 1
`define PEAK_BYTE_SEL_BIT 0

// Reset values
`define PEAK_BYTE_RESET 8'h00
`define PEAK_CODE_RESET 16'h0000
`define PEAK_UNMAPPED_DATA 8'h00

// Channels kept by this bank
`define PEAK_FIRST_CHAN 3
`define PEAK_LAST_CHAN 7

`endif

// ---- include/peak_hold_pkg.sv ----
// Types shared by the peak-hold register bank and its holding cell.
// Assumes a 16-bit code word from the conversion engine.
package peak_hold_pkg;

  // One stored register byte
  typedef logic [7:0] reg_byte_t;

  // Full held code, high byte over low byte
  typedef logic [15:0] peak_code_t;

  // Result handed over by the conversion engine, one cycle wide
  typedef struct packed {
    logic valid;
    logic [2:0] channel;
    peak_code_t code;
  } conv_s;

  // Register read request from the serial interface engine
  typedef struct packed {
    logic strobe;
    reg_byte_t addr;
  } rd_req_s;

endpackage : peak_hold_pkg

// ---- core/peak_hold_cell.sv ----
// One channel's peak holder: 16-bit running maximum, bytes cleared apart.
// Assumes samples and clears arrive on mclk from same-domain logic.
`timescale 1ns/1ps
`include "peak_hold_defs.svh"

module peak_hold_cell
  import peak_hold_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic sample_valid,
  input wire peak_code_t sample_code,
  input wire logic clear_lo,
  input wire logic clear_hi,
  output peak_code_t peak
);

  peak_code_t next_peak; // Value for the next edge
  peak_code_t base; // Held value after this cycle's clears

  // Clear first, then let a larger sample win over the clear
  always_comb begin
    base = peak;
    if (clear_lo) begin
      base[7:0] = `PEAK_BYTE_RESET;
    end
    if (clear_hi) begin
      base[15:8] = `PEAK_BYTE_RESET;
    end
    // Whole-word compare so a low-byte carry never fakes a new peak
    if (sample_valid && (sample_code > base)) begin
      next_peak = sample_code;
    end else begin
      next_peak = base;
    end
  end

  // State register, synchronous reset to zero
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      peak <= `PEAK_CODE_RESET;
    end else begin
      peak <= next_peak;
    end
  end

endmodule : peak_hold_cell

// ---- core/peak_hold_regs.sv ----
// Contract
// - Keep each channel's largest code since read
// - Reading a byte returns it, then clears
// - All peak bytes reset to zero, 8 bits
// - Low byte even address, high byte next; channel 3 low and channel 7 high unmapped
// - Channel 3 high at 0x67, channel 5 pair
//
// Peak-hold register bank for channels 3 to 7, read-to-clear bytes.
// Assumes the serial interface engine issues one-cycle read strobes on
// mclk and the conversion engine posts one-cycle results on mclk.
`timescale 1ns/1ps
`include "peak_hold_defs.svh"

module peak_hold_regs
  import peak_hold_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire conv_s conv_in,
  input wire rd_req_s rd_req,
  output reg_byte_t rd_data,
  output logic rd_valid,
  output logic rd_hit
);

  // Held codes, one per covered channel
  peak_code_t peak_val [`PEAK_FIRST_CHAN:`PEAK_LAST_CHAN];

  // Per-channel byte clears from the read decode
  logic [`PEAK_LAST_CHAN:`PEAK_FIRST_CHAN] clr_lo;
  logic [`PEAK_LAST_CHAN:`PEAK_FIRST_CHAN] clr_hi;

  // Address decode results
  logic addr_in_bank; // Read lands on a covered byte
  logic [2:0] addr_chan; // Channel picked by the address
  logic addr_high; // High byte picked

  // Next values of the read answer
  reg_byte_t next_rd_data;
  logic next_rd_valid;
  logic next_rd_hit;

  // Address split: pairs start at even offsets
  always_comb begin
    addr_in_bank = (rd_req.addr >= `PEAK_FIRST_ADDR) &&
                   (rd_req.addr <= `PEAK_LAST_ADDR);
    addr_chan = rd_req.addr[`PEAK_CHAN_MSB:`PEAK_CHAN_LSB];
    addr_high = rd_req.addr[`PEAK_BYTE_SEL_BIT];
  end

  // Clear strobes: only the byte actually read is cleared
  always_comb begin
    clr_lo = '0;
    clr_hi = '0;
    for (int c = `PEAK_FIRST_CHAN; c <= `PEAK_LAST_CHAN; c++) begin
      if (rd_req.strobe && addr_in_bank && (addr_chan == 3'(c))) begin
        clr_lo[c] = !addr_high;
        clr_hi[c] = addr_high;
      end
    end
  end

  // One holding cell per channel; unmapped halves stay internal
  for (genvar g = `PEAK_FIRST_CHAN; g <= `PEAK_LAST_CHAN; g++) begin : g_chan
    peak_hold_cell u_cell (
      .mclk(mclk),
      .reset_n(reset_n),
      .sample_valid(conv_in.valid && (conv_in.channel == 3'(g))),
      .sample_code(conv_in.code),
      .clear_lo(clr_lo[g]),
      .clear_hi(clr_hi[g]),
      .peak(peak_val[g])
    );
  end

  // Read mux: returns the value held before this edge's clear
  always_comb begin
    next_rd_valid = rd_req.strobe;
    next_rd_hit = 1'b0;
    next_rd_data = `PEAK_UNMAPPED_DATA;
    if (rd_req.strobe && addr_in_bank) begin
      next_rd_hit = 1'b1;
      // Held value leaves before the clear lands, so nothing is lost
      if (addr_high) begin
        next_rd_data = peak_val[addr_chan][15:8];
      end else begin
        next_rd_data = peak_val[addr_chan][7:0];
      end
    end
  end

  // Answer registers, so outputs come straight from flops
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      rd_data <= `PEAK_BYTE_RESET;
      rd_valid <= 1'b0;
      rd_hit <= 1'b0;
    end else begin
      rd_data <= next_rd_data;
      rd_valid <= next_rd_valid;
      rd_hit <= next_rd_hit;
    end
  end

  // Helper terms for the checks below
  logic rd_ch4, rd_ch5, rd_ch6, rd_ch7; // A read touches that channel
  assign rd_ch4 = rd_req.strobe && addr_in_bank && (addr_chan == 3'd4);
  assign rd_ch5 = rd_req.strobe && addr_in_bank && (addr_chan == 3'd5);
  assign rd_ch6 = rd_req.strobe && addr_in_bank && (addr_chan == 3'd6);
  assign rd_ch7 = rd_req.strobe && addr_in_bank && (addr_chan == 3'd7);

  // Largest seen code is taken when it beats the held value
  AST_TRACK_LARGER: assert property (
    @(posedge mclk) disable iff (!reset_n)
    (conv_in.valid && conv_in.channel == 3'd6 && !rd_ch6 &&
     conv_in.code > peak_val[6])
    |=> (peak_val[6] == $past(conv_in.code)))
    else $error("Channel 6 peak missed a larger code");

  // Without a read, a held peak never falls
  AST_NEVER_FALLS: assert property (
    @(posedge mclk) disable iff (!reset_n)
    !rd_ch5 |=> (peak_val[5] >= $past(peak_val[5])))
    else $error("Channel 5 peak dropped without a read");

  // High byte read returns old value, then the byte is zero
  AST_READ_CLEARS_HIGH: assert property (
    @(posedge mclk) disable iff (!reset_n)
    (rd_req.strobe && rd_req.addr == `PEAK_CH4_HIGH_BYTE_ADDR &&
     !(conv_in.valid && conv_in.channel == 3'd4))
    |=> (rd_data == $past(peak_val[4][15:8])) && rd_valid && rd_hit &&
        (peak_val[4][15:8] == 8'h00))
    else $error("Channel 4 high byte not returned then cleared");

  // A low byte read leaves the high byte alone when idle
  AST_CLEAR_ONLY_READ_BYTE: assert property (
    @(posedge mclk) disable iff (!reset_n)
    (rd_req.strobe && rd_req.addr == `PEAK_CH6_LOW_BYTE_ADDR && !conv_in.valid)
    |=> (peak_val[6][7:0] == 8'h00) &&
        (peak_val[6][15:8] == $past(peak_val[6][15:8])))
    else $error("Channel 6 low byte read disturbed the high byte");

  // Right after reset release every held code is zero
  AST_RESET_ZERO: assert property (
    @(posedge mclk) disable iff (!reset_n)
    $rose(reset_n) |-> (peak_val[3] == 16'h0000) && (peak_val[4] == 16'h0000) &&
                      (peak_val[5] == 16'h0000) && (peak_val[6] == 16'h0000) &&
                      (peak_val[7] == 16'h0000) && (rd_data == 8'h00) && !rd_valid)
    else $error("Peak state not zero after reset");

  // Channel 7 low byte sits at its own even address
  AST_CH7_LOW_ADDR: assert property (
    @(posedge mclk) disable iff (!reset_n)
    (rd_req.strobe && rd_req.addr == `PEAK_CH7_LOW_BYTE_ADDR)
    |=> rd_hit && (rd_data == $past(peak_val[7][7:0])))
    else $error("Channel 7 low byte read wrong");

  // Channel 4 low byte at its even address, pair with next
  AST_CH4_LOW_ADDR: assert property (
    @(posedge mclk) disable iff (!reset_n)
    (rd_req.strobe && rd_req.addr == `PEAK_CH4_LOW_BYTE_ADDR)
    |=> rd_hit && (rd_data == $past(peak_val[4][7:0])))
    else $error("Channel 4 low byte read wrong");

  // Channel 3 high byte readable at its offset
  AST_CH3_HIGH_ADDR: assert property (
    @(posedge mclk) disable iff (!reset_n)
    (rd_req.strobe && rd_req.addr == `PEAK_CH3_HIGH_BYTE_ADDR)
    |=> rd_hit && rd_valid && (rd_data == $past(peak_val[3][15:8])))
    else $error("Channel 3 high byte read wrong");

  // Channel 5 pair: high byte at the odd address
  AST_CH5_HIGH_ADDR: assert property (
    @(posedge mclk) disable iff (!reset_n)
    (rd_req.strobe && rd_req.addr == `PEAK_CH5_HIGH_BYTE_ADDR)
    |=> rd_hit && (rd_data == $past(peak_val[5][15:8])))
    else $error("Channel 5 high byte read wrong");

  // Byte just below the bank is not this block's
  AST_UNMAPPED_BELOW: assert property (
    @(posedge mclk) disable iff (!reset_n)
    (rd_req.strobe && rd_req.addr == 8'h66)
    |=> !rd_hit && rd_valid && (rd_data == 8'h00))
    else $error("Address below bank answered as mapped");

  // Equal or smaller codes leave the held peak untouched
  AST_NO_UPDATE_SMALL: assert property (
    @(posedge mclk) disable iff (!reset_n)
    (conv_in.valid && conv_in.channel == 3'd7 && !rd_ch7 &&
     conv_in.code <= peak_val[7])
    |=> $stable(peak_val[7]))
    else $error("Channel 7 peak changed on a code not larger");

  // Codes for another channel do not touch channel 4
  AST_OTHER_CHANNEL: assert property (
    @(posedge mclk) disable iff (!reset_n)
    (!rd_ch4 && !(conv_in.valid && conv_in.channel == 3'd4))
    |=> $stable(peak_val[4]))
    else $error("Channel 4 peak moved without its own code");

  // Channel 5 low byte at the even address of its pair
  AST_CH5_LOW_ADDR: assert property (
    @(posedge mclk) disable iff (!reset_n)
    (rd_req.strobe && rd_req.addr == `PEAK_CH5_LOW_BYTE_ADDR)
    |=> rd_hit && rd_valid && (rd_data == $past(peak_val[5][7:0])))
    else $error("Channel 5 low byte read wrong");

  // Channel 6 high byte sits just above its low byte
  AST_CH6_HIGH_ADDR: assert property (
    @(posedge mclk) disable iff (!reset_n)
    (rd_req.strobe && rd_req.addr == `PEAK_CH6_HIGH_BYTE_ADDR)
    |=> rd_hit && rd_valid && (rd_data == $past(peak_val[6][15:8])))
    else $error("Channel 6 high byte read wrong");

  // Byte above the bank answers empty and clears nothing;
  // the unmapped channel 7 high half must survive such a read
  AST_UNMAPPED_ABOVE: assert property (
    @(posedge mclk) disable iff (!reset_n)
    (rd_req.strobe && rd_req.addr == 8'h6f && !conv_in.valid)
    |=> !rd_hit && rd_valid && (rd_data == 8'h00) && $stable(peak_val[7]))
    else $error("Address above bank answered or cleared");

  // Cycles without a strobe answer show an empty, unflagged byte
  AST_IDLE_ANSWER_ZERO: assert property (
    @(posedge mclk) disable iff (!reset_n)
    !rd_req.strobe |=> !rd_valid && !rd_hit && (rd_data == `PEAK_BYTE_RESET))
    else $error("Read answer shown without a strobe");

endmodule : peak_hold_regs

// ---- dv/peak_code_hold_regs_tb.sv ----
// Self-checking bench for the peak-hold register bank, channels 3 to 7.
// Assumes the bank answers each read strobe one mclk later, no partner.
`timescale 1ns/1ps

module peak_code_hold_regs_tb
  import peak_hold_pkg::*;
;
  logic mclk; // 100 MHz clock
  logic reset_n; // Synchronous reset, active low
  conv_s conv_in; // Conversion results fed in
  rd_req_s rd_req; // Byte read requests
  reg_byte_t rd_data;
  logic rd_valid;
  logic rd_hit;
  int fails; // Mismatches seen
  int checks; // Comparisons made
  logic [7:0] a; // Sweep address
  logic [7:0] c; // Sweep channel
  logic [7:0] bad [4] = '{8'h66, 8'h6f, 8'h00, 8'hff}; // Outside the bank

  peak_hold_regs dut (
    .mclk(mclk),
    .reset_n(reset_n),
    .conv_in(conv_in),
    .rd_req(rd_req),
    .rd_data(rd_data),
    .rd_valid(rd_valid),
    .rd_hit(rd_hit)
  );

  // Free-running clock, 10 ns period
  initial mclk = 1'h0;
  always #5 mclk = ~mclk;

  // One compare, four-state exact
  task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Post one result; valid stays up so back-to-back posts need no gap
  task post(input logic [2:0] ch, input logic [15:0] code);
    rd_req.strobe = 1'h0;
    conv_in = '{valid: 1'h1, channel: ch, code: code};
    @(posedge mclk);
    #1;
  endtask : post

  // Read one byte; the answer lands exactly one edge later
  task rd(input logic [7:0] addr, input logic [7:0] exp, input logic hit);
    conv_in.valid = 1'h0;
    rd_req = '{strobe: 1'h1, addr: addr};
    @(posedge mclk);
    #1;
    chk("rd_valid", {15'h0000, rd_valid}, 16'h0001);
    chk("rd_hit", {15'h0000, rd_hit}, {15'h0000, hit});
    chk("rd_data", {8'h00, rd_data}, {8'h00, exp});
  endtask : rd

  // Quiet cycle; the answer pulse must have dropped
  task idle;
    rd_req.strobe = 1'h0;
    conv_in.valid = 1'h0;
    @(posedge mclk);
    #1;
    chk("rd_valid idle", {15'h0000, rd_valid}, 16'h0000);
    chk("rd_data idle", {8'h00, rd_data}, 16'h0000);
  endtask : idle

  // Read every mapped byte; filled pattern is hi 0x10+ch, lo 0x20+ch
  task sweep(input logic filled);
    for (a = 8'h67; a <= 8'h6e; a++) begin
      c = {5'h00, a[3:1]};
      rd(a, !filled ? 8'h00 : (a[0] ? 8'h10 + c : 8'h20 + c), 1'h1);
    end
    idle();
  endtask : sweep

  // Count summary, verdict, end of run
  task results;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : results

  // Watchdog: whole run is under a hundred cycles
  initial begin
    #20000;
    fails++;
    results();
  end

  // Main sequence
  initial begin
    reset_n = 1'h0;
    conv_in = '0;
    rd_req = '0;
    repeat (2) @(posedge mclk);
    #1;
    reset_n = 1'h1;
    idle();
    sweep(1'h0);
    $display("test reset values done");
    // Fill every channel back to back, then probe unmapped bytes
    for (c = 8'h03; c <= 8'h07; c++) post(c[2:0], {8'h10 + c, 8'h20 + c});
    foreach (bad[k]) rd(bad[k], 8'h00, 1'h0);
    sweep(1'h1);
    sweep(1'h0);
    $display("test map and clear-on-read done");
    // Running maximum: larger loads, equal and smaller are ignored
    post(3'h4, 16'h0150);
    post(3'h4, 16'h0200);
    post(3'h4, 16'h01ff);
    post(3'h5, 16'h00ff);
    post(3'h5, 16'h0100); // Low byte falls, word still larger
    // Channel 7 still holds its unmapped high half 0x17 here
    post(3'h7, 16'h1850);
    post(3'h7, 16'h1840); // Smaller, ignored
    post(3'h7, 16'h1850); // Equal, ignored
    rd(8'h68, 8'h00, 1'h1);
    rd(8'h69, 8'h02, 1'h1);
    rd(8'h6a, 8'h00, 1'h1);
    rd(8'h6b, 8'h01, 1'h1);
    rd(8'h6e, 8'h50, 1'h1);
    $display("test running maximum done");
    // Clearing one byte lets tracking restart against the remainder
    post(3'h6, 16'h0305);
    rd(8'h6c, 8'h05, 1'h1);
    post(3'h6, 16'h0302);
    rd(8'h6d, 8'h03, 1'h1);
    rd(8'h6c, 8'h02, 1'h1);
    rd(8'h6d, 8'h00, 1'h1);
    // Read and result on one channel in one cycle: old byte out, then compare
    post(3'h6, 16'h0180);
    rd_req = '{strobe: 1'h1, addr: 8'h6c};
    conv_in = '{valid: 1'h1, channel: 3'h6, code: 16'h0140};
    @(posedge mclk);
    #1;
    chk("rd_data same cycle", {8'h00, rd_data}, 16'h0080);
    rd(8'h6c, 8'h40, 1'h1);
    rd(8'h6d, 8'h01, 1'h1);
    idle();
    $display("test partial clear done");
    // Mid-run reset wipes a held peak
    post(3'h3, 16'hab00);
    idle();
    reset_n = 1'h0;
    repeat (2) @(posedge mclk);
    #1;
    reset_n = 1'h1;
    rd(8'h67, 8'h00, 1'h1);
    idle();
    $display("test mid-run reset done");
    results();
  end
endmodule : peak_code_hold_regs_tb
